//--- design/lpb_pkg.sv
package lpb_pkg;

   // Register offsets on the internal register port
   localparam logic [7:0] LPB_OFS_PHASE_ZERO = 8'h01;
   localparam logic [7:0] LPB_OFS_PHASE_ONE  = 8'h09;
   localparam logic [7:0] LPB_OFS_MASTER     = 8'h0E;
   localparam logic [7:0] LPB_OFS_INDIV_BASE = 8'h10;
   localparam logic [7:0] LPB_OFS_INDIV_LAST = 8'h13;

   // Reset values: outputs high impedance, PWM off
   localparam logic [7:0] LPB_RST_PHASE      = 8'hFF;
   localparam logic [7:0] LPB_RST_MASTER     = 8'h00;
   localparam logic [7:0] LPB_RST_INDIV      = 8'hFF;

   // Field positions of the master and ninth intensity register
   localparam int         LPB_MASTER_MSB     = 7;
   localparam int         LPB_MASTER_LSB     = 4;
   localparam int         LPB_NINTH_MSB      = 3;
   localparam int         LPB_NINTH_LSB      = 0;

   // PWM frame: 15 master timeslots of 16 cycles
   localparam logic [3:0] LPB_CYCLE_LAST     = 4'hF;
   localparam logic [3:0] LPB_SLOT_LAST      = 4'hE;
   localparam logic [3:0] LPB_STATIC_VALUE   = 4'hF;
   localparam logic [3:0] LPB_MASTER_OFF_MAX = 4'h0;

   // PWM cycle timing
   localparam int         LPB_CLK_HZ         = 125000000;
   localparam int         LPB_PWM_HZ         = 32000;
   localparam int         LPB_PWM_DIV        = LPB_CLK_HZ / LPB_PWM_HZ;

   localparam int         LPB_PORTS          = 8;

endpackage : lpb_pkg

//--- design/lpb_pwm_timebase.sv
`timescale 1ns/100ps
`default_nettype none

module lpb_pwm_timebase
   import lpb_pkg::*;
#(
   parameter int DIV_CYCLES = LPB_PWM_DIV
)
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   // Control
   input  wire logic       run_in,
   // Position inside the PWM frame
   output logic [3:0]      cycle_out,
   output logic [3:0]      slot_out
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check: a zero divider would never produce a tick
   if (DIV_CYCLES < 1)
   begin : g_div_check
      $error("DIV_CYCLES must be at least 1");
   end

   logic [31:0] div_reg;
   logic        tick;

   // Divider stands in for the slow PWM oscillator
   assign tick = run_in && (div_reg == 32'(DIV_CYCLES - 1));

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         div_reg <= '0;
      else if (!run_in || tick)
         div_reg <= '0; // Stopped oscillator restarts the frame cleanly
      else
         div_reg <= div_reg + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // 16 cycles per timeslot, 15 timeslots per frame
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cycle_out <= 4'h0;
         slot_out  <= 4'h0;
      end
      else if (!run_in)
      begin
         cycle_out <= 4'h0;
         slot_out  <= 4'h0;
      end
      else if (tick)
      begin
         cycle_out <= cycle_out + 4'h1;
         if (cycle_out == LPB_CYCLE_LAST)
            slot_out <= (slot_out == LPB_SLOT_LAST) ? 4'h0 : slot_out + 4'h1;
      end
   end

endmodule : lpb_pwm_timebase

`default_nettype wire

//--- design/lpb_led_pwm.sv
// What this block does
// - Master 0x00-0x0F: all outputs static, no PWM
// - Individual mode uses each output's own nibble
// - Individual value 0xF gives static output
// - Values 0x0-0xE are pulse-width modulated
// - Global mode uses only register 0x0E
// - Global intensity applies to all outputs together
// - Phase 0 register at 0x01, read back
// - Phase 1 register at 0x09, read back
// - Frame: 15 timeslots of 16 cycles
// - Blink enable and flip select phase register
// - Bit 1 high impedance, bit 0 low
// - Setting 16/16 ignores master gating, static
`timescale 1ns/100ps
`default_nettype none

module lpb_led_pwm
   import lpb_pkg::*;
#(
   parameter int DIV_CYCLES = LPB_PWM_DIV
)
(
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_b_in,
   // Register port from the serial interface
   input  wire logic                   wr_en_in,
   input  wire logic [7:0]             addr_in,
   input  wire logic [7:0]             wr_data_in,
   output logic [7:0]                  rd_data_out,
   // Configuration bits held elsewhere
   input  wire logic                   blink_enable_in,
   input  wire logic                   blink_flip_in,
   input  wire logic                   global_intensity_in,
   input  wire logic                   ninth_level_phase_zero_in,
   input  wire logic                   ninth_level_phase_one_in,
   // Open-drain port pins, enable high while pulling low
   output logic [LPB_PORTS-1:0]        port_pins_out,
   output logic [LPB_PORTS-1:0]        port_pins_oe_out,
   output logic                        ninth_output_out,
   output logic                        ninth_output_oe_out
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check: a zero divider would never advance the timebase
   if (DIV_CYCLES < 1)
   begin : g_div_check
      $error("DIV_CYCLES must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  phase_zero_reg;
   logic [7:0]  phase_one_reg;
   logic [7:0]  master_reg;
   logic [7:0]  indiv_reg [0:3];
   logic [3:0]  cycle;
   logic [3:0]  slot;
   logic        pwm_run;

   // Level for one output given its programmed bit and intensity
   function automatic logic pwm_level(input logic       level_bit,
                                      input logic [3:0] inten,
                                      input logic [3:0] master,
                                      input logic [3:0] slot_pos,
                                      input logic [3:0] cyc);
      logic gated;
      gated = 1'b0;
      if (master <= LPB_MASTER_OFF_MAX)
         pwm_level = level_bit;
      else if (inten == LPB_STATIC_VALUE)
         pwm_level = level_bit;
      else
      begin
         gated = (slot_pos < master);
         pwm_level = (gated && (cyc <= inten)) ? level_bit : ~level_bit;
      end
   endfunction : pwm_level

   // Address lies in the individual intensity window
   function automatic logic indiv_hit(input logic [7:0] addr);
      indiv_hit = (addr >= LPB_OFS_INDIV_BASE) &&
                  (addr <= LPB_OFS_INDIV_LAST);
   endfunction : indiv_hit

   // Slot of the individual intensity array that an address selects
   function automatic logic [1:0] indiv_index(input logic [7:0] addr);
      logic [7:0] ofs;
      ofs         = addr - LPB_OFS_INDIV_BASE;
      indiv_index = ofs[1:0];
   endfunction : indiv_index

   // Each individual register holds two ports: even low, odd high nibble
   function automatic logic [3:0] port_nibble(input logic [7:0] pair,
                                              input logic       upper);
      port_nibble = upper ? pair[7:4] : pair[3:0];
   endfunction : port_nibble

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         phase_zero_reg <= LPB_RST_PHASE;
         phase_one_reg  <= LPB_RST_PHASE;
         master_reg     <= LPB_RST_MASTER;
         for (int i = 0; i < 4; i++)
            indiv_reg[i] <= LPB_RST_INDIV;
      end
      else if (wr_en_in)
      begin
         case (addr_in)
            LPB_OFS_PHASE_ZERO: phase_zero_reg <= wr_data_in;
            LPB_OFS_PHASE_ONE:  phase_one_reg  <= wr_data_in;
            LPB_OFS_MASTER:     master_reg     <= wr_data_in;
            default:
            begin
               if (indiv_hit(addr_in))
                  indiv_reg[indiv_index(addr_in)] <= wr_data_in;
            end
         endcase
      end
   end

   // Read returns stored values, never the pin state
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         rd_data_out <= 8'h00;
      else
      begin
         case (addr_in)
            LPB_OFS_PHASE_ZERO: rd_data_out <= phase_zero_reg;
            LPB_OFS_PHASE_ONE:  rd_data_out <= phase_one_reg;
            LPB_OFS_MASTER:     rd_data_out <= master_reg;
            default:
            begin
               if (indiv_hit(addr_in))
                  rd_data_out <= indiv_reg[indiv_index(addr_in)];
               else
                  rd_data_out <= 8'h00;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master timeslot count, shared by every output and the timebase
   logic [3:0] master_inten;

   assign master_inten = master_reg[LPB_MASTER_MSB:LPB_MASTER_LSB];

   // Timebase stops while PWM is off, as the oscillator would; this also
   // restarts the frame from slot 0 whenever PWM is switched back on
   assign pwm_run = (master_inten > LPB_MASTER_OFF_MAX);

   lpb_pwm_timebase #(
      .DIV_CYCLES (DIV_CYCLES)
   ) u_timebase (
      .clk_in     (clk_in),
      .rst_b_in   (rst_b_in),
      .run_in     (pwm_run),
      .cycle_out  (cycle),
      .slot_out   (slot)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output stage: phase select, intensity select, registered pins
   logic [7:0] phase_sel;
   logic       ninth_sel;
   logic [3:0] ninth_inten;
   logic [3:0] inten_sel;
   logic [7:0] pins_oe_next;
   logic       ninth_oe_next;

   assign phase_sel   = (blink_enable_in && blink_flip_in) ?
                        phase_one_reg : phase_zero_reg;
   assign ninth_sel   = (blink_enable_in && blink_flip_in) ?
                        ninth_level_phase_one_in :
                        ninth_level_phase_zero_in;
   assign ninth_inten = master_reg[LPB_NINTH_MSB:LPB_NINTH_LSB];

   // Per-port intensity and level, worked out ahead of the pin flops.
   // Global mode overrides every nibble, so no port can stay static alone.
   always_comb
   begin
      pins_oe_next = '0;
      inten_sel    = 4'h0;
      for (int p = 0; p < LPB_PORTS; p++)
      begin
         inten_sel = global_intensity_in ? ninth_inten
                   : port_nibble(indiv_reg[p/2], p[0]);
         pins_oe_next[p] = ~pwm_level(phase_sel[p], inten_sel, master_inten,
                                      slot, cycle);
      end
      ninth_oe_next = ~pwm_level(ninth_sel, ninth_inten, master_inten,
                                 slot, cycle);
   end

   // Registered enables keep decode glitches off the open-drain pins
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         port_pins_oe_out    <= '0;
         ninth_output_oe_out <= 1'b0;
      end
      else
      begin
         port_pins_oe_out    <= pins_oe_next;
         ninth_output_oe_out <= ninth_oe_next;
      end
   end

   // Open-drain data stays low; only the enables ever move
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         port_pins_out    <= '0;
         ninth_output_out <= 1'b0;
      end
      else
      begin
         port_pins_out    <= '0;
         ninth_output_out <= 1'b0;
      end
   end

endmodule : lpb_led_pwm

`default_nettype wire

//--- tb/lpb_load_model.sv
`timescale 1ns/100ps
`default_nettype none

module lpb_load_model
   import lpb_pkg::*;
(
   // Pin drive from the block
   input  wire logic [LPB_PORTS-1:0] oe_in,
   // Level seen on the wire
   output logic      [LPB_PORTS-1:0] level_out
);
   // Pull-up on each line, so a released pin reads high
   assign level_out = ~oe_in;
endmodule : lpb_load_model
`default_nettype wire

//--- tb/lpb_led_pwm_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module lpb_led_pwm_asserts
   import lpb_pkg::*;
(
   // Watched ports
   input wire logic       clk_in,
   input wire logic       rst_b_in,
   input wire logic       wr_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [7:0] rd_data_out,
   input wire logic       blink_enable_in,
   input wire logic       blink_flip_in,
   input wire logic       global_intensity_in,
   input wire logic       ninth_level_phase_zero_in,
   input wire logic       ninth_level_phase_one_in,
   input wire logic [7:0] port_pins_out,
   input wire logic [7:0] port_pins_oe_out,
   input wire logic       ninth_output_out,
   input wire logic       ninth_output_oe_out
);
   logic [7:0] ph0_reg;
   logic [7:0] ph1_reg;
   logic [7:0] mst_reg;
   logic [7:0] ind_reg;
   logic [7:0] sel;
   logic       stat;
   logic       nsel;
   ////////////////////
   // Shadow of written registers, so pin checks know what was programmed
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ph0_reg <= LPB_RST_PHASE;
         ph1_reg <= LPB_RST_PHASE;
         mst_reg <= LPB_RST_MASTER;
         ind_reg <= LPB_RST_INDIV;
      end
      else if (wr_en_in)
      begin
         if (addr_in == LPB_OFS_PHASE_ZERO) ph0_reg <= wr_data_in;
         if (addr_in == LPB_OFS_PHASE_ONE) ph1_reg <= wr_data_in;
         if (addr_in == LPB_OFS_MASTER) mst_reg <= wr_data_in;
         if (addr_in == LPB_OFS_INDIV_BASE) ind_reg <= wr_data_in;
      end
   end
   // Phase in use and static mode
   assign sel  = (blink_enable_in & blink_flip_in) ? ph1_reg : ph0_reg;
   assign nsel = (blink_enable_in & blink_flip_in) ?
                 ninth_level_phase_one_in : ninth_level_phase_zero_in;
   assign stat = (mst_reg[7:4] == 4'h0);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   a_pins_data_low: assert property
      (port_pins_out == 8'h00 && !ninth_output_out) else $error("data");
   a_phase0_readback: assert property
      (wr_en_in && addr_in == 8'h01 ##1 !wr_en_in && addr_in == 8'h01
      |=> rd_data_out == $past(wr_data_in, 2)) else $error("phase 0");
   a_phase1_readback: assert property
      (wr_en_in && addr_in == 8'h09 ##1 !wr_en_in && addr_in == 8'h09
      |=> rd_data_out == $past(wr_data_in, 2)) else $error("phase 1");
   a_unmapped_zero: assert property
      (addr_in == 8'h05 |=> rd_data_out == 8'h00) else $error("unmapped");
   a_static_levels: assert property
      (stat |=> port_pins_oe_out == ~$past(sel)) else $error("static");
   a_ninth_static: assert property
      (stat |=> ninth_output_oe_out == !$past(nsel)) else $error("ninth");
   a_indiv_static: assert property
      (!stat && !global_intensity_in && ind_reg[3:0] == 4'hF
      |=> port_pins_oe_out[0] == !$past(sel[0])) else $error("indiv");
   a_global_static: assert property
      (!stat && global_intensity_in && mst_reg[3:0] == 4'hF
      |=> port_pins_oe_out == ~$past(sel)) else $error("global");
endmodule : lpb_led_pwm_asserts

bind lpb_led_pwm lpb_led_pwm_asserts i_lpb_led_pwm_asserts (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .wr_en_in(wr_en_in),
   .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
   .blink_enable_in(blink_enable_in), .blink_flip_in(blink_flip_in),
   .global_intensity_in(global_intensity_in),
   .ninth_level_phase_zero_in(ninth_level_phase_zero_in),
   .ninth_level_phase_one_in(ninth_level_phase_one_in),
   .port_pins_out(port_pins_out), .port_pins_oe_out(port_pins_oe_out),
   .ninth_output_out(ninth_output_out),
   .ninth_output_oe_out(ninth_output_oe_out));
`default_nettype wire

//--- tb/tb_lpb_led_pwm.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
   begin \
      compares++; \
      if ((a) !== (b)) \
      begin \
         fails++; \
         $display("MISMATCH %0t got %0h expected %0h", $time, (a), (b)); \
      end \
   end

module tb_lpb_led_pwm;
   logic       clk_in = 1'b0;
   logic       rst_b_in = 1'b0;
   logic       wr_en_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00;
   logic [4:0] cfg = 5'h01; // Blink enable, flip, global, ninth levels
   logic [7:0] rd_data_out;
   logic [7:0] oe;
   logic [7:0] level;
   logic       n_oe;
   logic [8:0] pins; // Ninth line above the eight port lines
   int         fails = 0;
   int         compares = 0;
   int         cycles = 0;
   ////////////////////
   lpb_led_pwm #(.DIV_CYCLES(2)) i_lpb_led_pwm (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .wr_en_in(wr_en_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
      .blink_enable_in(cfg[4]), .blink_flip_in(cfg[3]),
      .global_intensity_in(cfg[2]), .ninth_level_phase_one_in(cfg[1]),
      .ninth_level_phase_zero_in(cfg[0]), .port_pins_out(),
      .port_pins_oe_out(oe), .ninth_output_out(), .ninth_output_oe_out(n_oe));
   lpb_load_model i_lpb_load_model (.oe_in(oe), .level_out(level));
   // Ninth line has its own pull-up, so it reads as the inverse enable
   assign pins = {~n_oe, level};
   // 125 MHz clock
   always #4 clk_in = ~clk_in;
   // Hang guard: the run needs some 3500 cycles
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         fails++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   // One write; strobe high for a single edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask : wr
   // Read data is registered, so look two edges on
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr_in <= a;
      repeat (2) @(posedge clk_in);
      #1 `CHK(rd_data_out, e)
   endtask : rd
   // Low and high clocks of one pin over a whole 480-clock frame, phase
   // free; an unknown level counts as neither, so it cannot slip through
   task automatic cnt(input int p, input int e);
      int lo;
      int hi;
      lo = 0;
      hi = 0;
      repeat (8) @(posedge clk_in);
      repeat (480)
      begin
         @(posedge clk_in);
         #1 lo += int'(pins[p] === 1'b0);
         hi += int'(pins[p] === 1'b1);
      end
      `CHK(lo, e)
      `CHK(hi, 480 - e)
   endtask : cnt
   task automatic t_regs();
      rd(8'h01, 8'hFF);
      rd(8'h09, 8'hFF);
      rd(8'h0E, 8'h00);
      wr(8'h01, 8'h5A);
      wr(8'h09, 8'hC3);
      wr(8'h05, 8'h77);
      rd(8'h01, 8'h5A);
      rd(8'h09, 8'hC3);
      rd(8'h05, 8'h00);
   endtask : t_regs
   // Static master: global flag set yet ignored
   task automatic t_static();
      wr(8'h0E, 8'h0F);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_in);
         cfg <= {i[1:0], 3'b101};
         repeat (3) @(posedge clk_in);
         #1 `CHK(level, (i == 3) ? 8'hC3 : 8'h5A)
         `CHK(n_oe, i == 3)
      end
   endtask : t_static
   // Port 0 static at 0xF, port 1 at 3/16 in 3 of 15 slots
   task automatic t_indiv();
      wr(8'h01, 8'h00);
      cfg <= 5'h01;
      wr(8'h10, 8'h2F);
      wr(8'h13, 8'h2F);
      rd(8'h13, 8'h2F);
      wr(8'h0E, 8'h30);
      cnt(0, 480);
      cnt(1, 18);
      cnt(7, 18);
      cnt(8, 474);
      wr(8'h01, 8'h02);
      cnt(1, 462);
   endtask : t_indiv
   // Global 6/16 in 2 slots; individual nibbles must not matter
   task automatic t_global();
      wr(8'h0E, 8'h25);
      cfg <= 5'h05;
      cnt(0, 24);
      cnt(1, 456);
      wr(8'h0E, 8'h2F);
      repeat (3) @(posedge clk_in);
      #1 `CHK(level, 8'h02)
   endtask : t_global
   initial
   begin
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_regs();
      t_static();
      t_indiv();
      t_global();
      end_sim();
   end
endmodule : tb_lpb_led_pwm
`default_nettype wire
